// File: inc/pfcvp_pkg.sv
// Purpose: shared constants of the pfc valley and fault protection block
// Assumes: pclk at 100 MHz, sense codes of 0.1 uA per lsb
// Notes:   register map is on a 32-bit apb bus, one word per register
package pfcvp_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int SENSE_W = 12;
   localparam int APB_AW = 8;

   // times in their own units, cycle counts derived from the clock period
   localparam int VALLEY_QUALIFY_NS = 200;
   localparam int VALLEY_QUALIFY_CYC = (VALLEY_QUALIFY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LEB_NS = 300;
   localparam int LEB_CYC = (LEB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BROWNOUT_DWELL_MS = 56;
   localparam int BROWNOUT_DWELL_CYC = BROWNOUT_DWELL_MS * 1000000 / CLK_PERIOD_NS;
   localparam int RESTART_US = 1600;
   localparam int RESTART_CYC = RESTART_US * 1000 / CLK_PERIOD_NS;
   localparam int OVERLOAD_MS = 112;
   localparam int OVERLOAD_CYC = OVERLOAD_MS * 1000000 / CLK_PERIOD_NS;
   localparam longint SHUTDOWN_MS = 2500;
   localparam int SHUTDOWN_CYC = int'(SHUTDOWN_MS * 1000000 / CLK_PERIOD_NS);

   // sense levels in 0.1 uA codes
   localparam int REF_CODE = 1290;
   localparam int OVP_TRIP_PCT = 105;
   localparam int OVP_TRIP_CODE = REF_CODE * OVP_TRIP_PCT / 100;
   localparam int STARTUP_PCT = 90;
   localparam int STARTUP_CODE = REF_CODE * STARTUP_PCT / 100;
   localparam int BO_LOW_RST = 316;
   localparam int BO_HIGH_RST = 396;
   localparam int OVP_HYST_RST = 26;

   // register byte offsets
   localparam logic [APB_AW-1:0] ADDR_CTRL = 8'h00;
   localparam logic [APB_AW-1:0] ADDR_BO_LOW = 8'h04;
   localparam logic [APB_AW-1:0] ADDR_BO_HIGH = 8'h08;
   localparam logic [APB_AW-1:0] ADDR_OVP_HYST = 8'h0C;
   localparam logic [APB_AW-1:0] ADDR_STATUS = 8'h10;
   localparam logic [APB_AW-1:0] ADDR_VALLEY_CNT = 8'h14;
   localparam logic CTRL_EN_RST = 1'b1;

   // status register bit positions
   localparam int ST_BROWNOUT = 0;
   localparam int ST_OVP = 1;
   localparam int ST_RESTART = 2;
   localparam int ST_SHUTDOWN = 3;
   localparam int ST_STARTUP = 4;
   localparam int ST_POWER_LIMIT = 5;
   localparam int ST_GATE = 6;
   localparam int ST_OVERLOAD = 7;
   localparam int STATUS_W = 8;
endpackage : pfcvp_pkg

// File: hw/pfcvp_dwell_timer.sv
// Purpose: counts cycles while a condition holds, flags when the limit is reached
// Assumes: run is synchronous to pclk
// Notes:   done stays high one cycle after run drops, so a falling edge can still see it
`timescale 1ns/1ps
module pfcvp_dwell_timer
   import pfcvp_pkg::*;
#(
   parameter int LIMIT = VALLEY_QUALIFY_CYC
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // condition and result
   input wire logic run,
   output logic done
);
   localparam int CW = $clog2(LIMIT + 1);

   typedef struct packed {
      logic [CW-1:0] cnt;
   } pfcvp_timer_t;

   pfcvp_timer_t st_reg;
   pfcvp_timer_t st_next;

   always_comb begin
      st_next = st_reg;
      if (!run) begin
         st_next.cnt = '0;
      end else if (st_reg.cnt != CW'(LIMIT)) begin
         st_next.cnt = st_reg.cnt + CW'(1);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign done = (st_reg.cnt == CW'(LIMIT));
endmodule : pfcvp_dwell_timer

// File: hw/pfcvp_protect.sv
// Purpose: valley qualification and fault protection gating the boost gate drive
// Assumes: all inputs synchronous to pclk; sense inputs are 0.1 uA codes
// Notes:   on-time length and frequency come from the outside calculator
//
// Summary of operation
// RULE1 - valley pulse only after comparator high without break for 200 ns
// RULE2 - a falling edge without full qualification gives no pulse and no cycle
// RULE3 - valleys may be skipped; a cycle starts only on a requested qualified valley
// RULE4 - brownout compares the digitised line sense current with its thresholds
// RULE5 - below low level for over 56 ms declares brownout and stops gating
// RULE6 - brownout ends after line sense stays above high level 56 ms
// RULE7 - brownout levels reset to 31.6 uA and 39.6 uA, giving hysteresis
// RULE8 - brownout means standby; recovery returns to normal operation
// RULE9 - feedback above 105 percent of reference stops the gate at once
// RULE10 - after overvoltage, gating resumes below trip level minus hysteresis
// RULE11 - cycle overcurrent checked only while on and after blanking
// RULE12 - cycle limit comparator ends the on-time immediately
// RULE13 - severe limit stops the gate and blocks switching 1.6 ms, then restarts
// RULE14 - moderate overload in normal mode holds rated power while link droops
// RULE15 - link below startup threshold enters startup; nominal cancels it
// RULE16 - persisting overload repeats droop, startup and rated limiting
// RULE17 - startup below 90 percent of nominal, kept until nominal again
// RULE18 - feedback reference current is 129 uA
// RULE19 - overload over 112 ms shuts down 2.5 s, then restarts
// RULE20 - gate allowed only with no brownout, overvoltage, overcurrent or inhibit
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/1ps
module pfcvp_protect
   import pfcvp_pkg::*;
#(
   parameter int BO_DWELL = BROWNOUT_DWELL_CYC,
   parameter int RESTART_LEN = RESTART_CYC,
   parameter int OVERLOAD_LEN = OVERLOAD_CYC,
   parameter int SHUTDOWN_LEN = SHUTDOWN_CYC
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // sense inputs
   input wire logic valley_detect_input,
   input wire logic [SENSE_W-1:0] line_sense_input,
   input wire logic [SENSE_W-1:0] link_feedback_input,
   input wire logic cycle_limit_cmp,
   input wire logic severe_limit_cmp,
   // from the on-time calculator
   input wire logic cycle_request,
   input wire logic on_time_end,
   input wire logic power_at_limit,
   // outputs
   output logic gate_drive_output,
   output logic valley_qualified_pulse,
   output logic startup_mode,
   output logic standby_mode,
   output logic power_limit_active
);
   localparam int RW = $clog2(RESTART_LEN + 1);
   localparam int OW = $clog2(OVERLOAD_LEN + 1);
   localparam int SW = $clog2(SHUTDOWN_LEN + 1);

   typedef struct packed {
      logic [31:0] prdata;
      logic ctrl_en;
      logic [SENSE_W-1:0] bo_low;
      logic [SENSE_W-1:0] bo_high;
      logic [SENSE_W-1:0] ovp_hyst;
      logic prev_valley;
      logic valley_pulse;
      logic [15:0] valley_cnt;
      logic gate_on;
      logic brownout;
      logic overvoltage_protection;
      logic startup;
      logic had_normal;
      logic plim;
      logic [RW-1:0] restart_cnt;
      logic [OW-1:0] overload_cnt;
      logic [SW-1:0] shutdown_cnt;
   } pfcvp_state_t;

   localparam pfcvp_state_t ST_RESET = '{
      prdata: 32'h0,
      ctrl_en: CTRL_EN_RST,
      bo_low: SENSE_W'(BO_LOW_RST),
      bo_high: SENSE_W'(BO_HIGH_RST),
      ovp_hyst: SENSE_W'(OVP_HYST_RST),
      prev_valley: 1'b0,
      valley_pulse: 1'b0,
      valley_cnt: 16'h0,
      gate_on: 1'b0,
      brownout: 1'b0,
      overvoltage_protection: 1'b0,
      startup: 1'b1,
      had_normal: 1'b0,
      plim: 1'b0,
      restart_cnt: '0,
      overload_cnt: '0,
      shutdown_cnt: '0
   };

   pfcvp_state_t st_reg;
   pfcvp_state_t st_next;

   logic qual_done;
   logic leb_done;
   logic bo_low_done;
   logic bo_high_done;
   logic bo_low_run;
   logic bo_high_run;
   logic ovp_trip;
   logic valley_fire;
   logic ocp_window;
   logic severe_hit;
   logic cycle_cut;
   logic ov_cond;
   logic allow;
   logic brown_start;
   logic shut_start;
   logic addr_hit;
   logic [SENSE_W-1:0] ovp_release;
   logic [STATUS_W-1:0] status;

   // level dwell timers
   pfcvp_dwell_timer #(.LIMIT(VALLEY_QUALIFY_CYC)) u_qual (
      .pclk(pclk), .presetn(presetn), .run(valley_detect_input), .done(qual_done)); // [RULE1]
   pfcvp_dwell_timer #(.LIMIT(LEB_CYC)) u_leb (
      .pclk(pclk), .presetn(presetn), .run(st_reg.gate_on), .done(leb_done)); // [RULE11]
   pfcvp_dwell_timer #(.LIMIT(BO_DWELL)) u_bo_low (
      .pclk(pclk), .presetn(presetn), .run(bo_low_run), .done(bo_low_done)); // [RULE5]
   pfcvp_dwell_timer #(.LIMIT(BO_DWELL)) u_bo_high (
      .pclk(pclk), .presetn(presetn), .run(bo_high_run), .done(bo_high_done)); // [RULE6]

   assign bo_low_run = !st_reg.brownout && (line_sense_input < st_reg.bo_low); // [RULE4]
   assign bo_high_run = st_reg.brownout && (line_sense_input > st_reg.bo_high); // [RULE4]

   assign addr_hit = (paddr == ADDR_CTRL) || (paddr == ADDR_BO_LOW) || (paddr == ADDR_BO_HIGH) ||
                     (paddr == ADDR_OVP_HYST) || (paddr == ADDR_STATUS) || (paddr == ADDR_VALLEY_CNT);

   always_comb begin
      status = '0;
      status[ST_BROWNOUT] = st_reg.brownout;
      status[ST_OVP] = st_reg.overvoltage_protection;
      status[ST_RESTART] = (st_reg.restart_cnt != '0);
      status[ST_SHUTDOWN] = (st_reg.shutdown_cnt != '0);
      status[ST_STARTUP] = st_reg.startup;
      status[ST_POWER_LIMIT] = st_reg.plim;
      status[ST_GATE] = st_reg.gate_on;
      status[ST_OVERLOAD] = (st_reg.overload_cnt != '0);
   end

   always_comb begin
      st_next = st_reg;
      // trip level is 105 percent of the 129 uA reference
      ovp_trip = link_feedback_input > SENSE_W'(OVP_TRIP_CODE); // [RULE18]
      // hysteresis above the trip level wraps; software must keep it small
      ovp_release = SENSE_W'(OVP_TRIP_CODE) - st_reg.ovp_hyst;
      valley_fire = st_reg.prev_valley && !valley_detect_input && qual_done; // [RULE2]
      ocp_window = st_reg.gate_on && leb_done; // [RULE11]
      severe_hit = ocp_window && severe_limit_cmp;
      cycle_cut = ocp_window && cycle_limit_cmp;
      ov_cond = (!st_reg.startup && power_at_limit) || (st_reg.startup && st_reg.had_normal);
      // a fault flagged at this edge must already hold the gate off, not one cycle later
      brown_start = !st_reg.brownout && bo_low_done; // [RULE5]
      shut_start = (st_reg.shutdown_cnt == '0) && (st_reg.overload_cnt == OW'(OVERLOAD_LEN)); // [RULE19]
      allow = st_reg.ctrl_en && !st_reg.brownout && !st_reg.overvoltage_protection && !ovp_trip &&
              !brown_start && !shut_start &&
              (st_reg.restart_cnt == '0) && (st_reg.shutdown_cnt == '0); // [RULE20]

      // valley qualification
      st_next.prev_valley = valley_detect_input;
      st_next.valley_pulse = valley_fire; // [RULE1]
      if (valley_fire) begin
         st_next.valley_cnt = st_reg.valley_cnt + 16'h0001;
      end

      // brownout with separate entry and exit dwell
      if (!st_reg.brownout && bo_low_done) begin
         st_next.brownout = 1'b1; // [RULE5] [RULE8]
      end else if (st_reg.brownout && bo_high_done) begin
         st_next.brownout = 1'b0; // [RULE6] [RULE8]
      end

      // overvoltage, released only below the hysteresis band
      if (ovp_trip) begin
         st_next.overvoltage_protection = 1'b1; // [RULE9]
      end else if (link_feedback_input < ovp_release) begin
         st_next.overvoltage_protection = 1'b0; // [RULE10]
      end

      // startup mode below 90 percent, cleared at nominal
      if (link_feedback_input < SENSE_W'(STARTUP_CODE)) begin
         st_next.startup = 1'b1; // [RULE15] [RULE17]
      end else if (link_feedback_input >= SENSE_W'(REF_CODE)) begin
         st_next.startup = 1'b0; // [RULE15] [RULE17]
         st_next.had_normal = 1'b1;
      end
      // in normal mode the calculator caps power; link may droop to the startup level
      st_next.plim = !st_next.startup && power_at_limit; // [RULE14] [RULE16]

      // severe overcurrent restart inhibit
      if (severe_hit) begin
         st_next.restart_cnt = RW'(RESTART_LEN); // [RULE13]
      end else if (st_reg.restart_cnt != '0) begin
         st_next.restart_cnt = st_reg.restart_cnt - RW'(1);
      end

      // overload duration and long shutdown
      if (st_reg.shutdown_cnt != '0) begin
         st_next.shutdown_cnt = st_reg.shutdown_cnt - SW'(1);
         st_next.overload_cnt = '0;
      end else if (st_reg.overload_cnt == OW'(OVERLOAD_LEN)) begin
         st_next.shutdown_cnt = SW'(SHUTDOWN_LEN); // [RULE19]
         st_next.overload_cnt = '0;
      end else if (ov_cond) begin
         st_next.overload_cnt = st_reg.overload_cnt + OW'(1); // [RULE16]
      end else begin
         st_next.overload_cnt = '0;
      end

      // gate drive
      if (!allow || cycle_cut || severe_hit || on_time_end) begin
         st_next.gate_on = 1'b0; // [RULE12] [RULE13] [RULE20]
      end else if (!st_reg.gate_on && valley_fire && cycle_request) begin
         st_next.gate_on = 1'b1; // [RULE3]
      end

      // apb: read data captured in setup so it is a flop in the access phase
      if (psel && !penable) begin
         unique case (paddr)
            ADDR_CTRL: st_next.prdata = 32'(st_reg.ctrl_en);
            ADDR_BO_LOW: st_next.prdata = 32'(st_reg.bo_low);
            ADDR_BO_HIGH: st_next.prdata = 32'(st_reg.bo_high);
            ADDR_OVP_HYST: st_next.prdata = 32'(st_reg.ovp_hyst);
            ADDR_STATUS: st_next.prdata = 32'(status);
            ADDR_VALLEY_CNT: st_next.prdata = 32'(st_reg.valley_cnt);
            default: st_next.prdata = 32'h0;
         endcase
      end
      if (psel && penable && pwrite) begin
         unique case (paddr)
            ADDR_CTRL: st_next.ctrl_en = pwdata[0];
            ADDR_BO_LOW: st_next.bo_low = pwdata[SENSE_W-1:0]; // [RULE7]
            ADDR_BO_HIGH: st_next.bo_high = pwdata[SENSE_W-1:0]; // [RULE7]
            ADDR_OVP_HYST: st_next.ovp_hyst = pwdata[SENSE_W-1:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= ST_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   assign prdata = st_reg.prdata;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !addr_hit;
   assign gate_drive_output = st_reg.gate_on;
   assign valley_qualified_pulse = st_reg.valley_pulse;
   assign startup_mode = st_reg.startup;
   assign standby_mode = st_reg.brownout; // [RULE8]
   assign power_limit_active = st_reg.plim;

   a_valley_qualify: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
      valley_qualified_pulse |-> !$past(valley_detect_input, 1) && $past(valley_detect_input, 2) &&
      $past(valley_detect_input, 21))
      else $error("valley pulse without full qualify interval");
   a_glitch_reject: assert property (@(posedge pclk) disable iff (!presetn) // [RULE2]
      $fell(valley_detect_input) && !$past(valley_detect_input, 20) |=> !valley_qualified_pulse)
      else $error("glitch produced a valley pulse");
   a_gate_on_valley: assert property (@(posedge pclk) disable iff (!presetn) // [RULE3]
      $rose(gate_drive_output) |-> valley_qualified_pulse && $past(cycle_request))
      else $error("gate started without a requested qualified valley");
   a_bo_entry: assert property (@(posedge pclk) disable iff (!presetn) // [RULE5]
      $rose(standby_mode) |-> $past(bo_low_done) && !gate_drive_output)
      else $error("brownout entered before low dwell elapsed");
   a_bo_exit: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
      $fell(standby_mode) |-> $past(bo_high_done))
      else $error("brownout left before high dwell elapsed");
   a_ovp_stop: assert property (@(posedge pclk) disable iff (!presetn) // [RULE9]
      link_feedback_input > SENSE_W'(OVP_TRIP_CODE) |=> !gate_drive_output && st_reg.overvoltage_protection)
      else $error("gate not stopped on overvoltage");
   a_ovp_resume: assert property (@(posedge pclk) disable iff (!presetn) // [RULE10]
      $fell(st_reg.overvoltage_protection) |-> $past(link_feedback_input) < $past(ovp_release))
      else $error("overvoltage released above hysteresis level");
   a_leb_blank: assert property (@(posedge pclk) disable iff (!presetn) // [RULE11]
      gate_drive_output && !leb_done && allow && !on_time_end |=> gate_drive_output)
      else $error("gate cut inside blanking interval");
   a_cycle_limit: assert property (@(posedge pclk) disable iff (!presetn) // [RULE12]
      gate_drive_output && leb_done && cycle_limit_cmp |=> !gate_drive_output)
      else $error("cycle limit did not end on-time");
   a_severe_block: assert property (@(posedge pclk) disable iff (!presetn) // [RULE13]
      severe_hit |=> !gate_drive_output && st_reg.restart_cnt == RW'(RESTART_LEN))
      else $error("severe overcurrent did not start restart delay");
   a_startup_entry: assert property (@(posedge pclk) disable iff (!presetn) // [RULE17]
      link_feedback_input < SENSE_W'(STARTUP_CODE) |=> startup_mode)
      else $error("startup mode not entered below threshold");
   a_overload_shut: assert property (@(posedge pclk) disable iff (!presetn) // [RULE19]
      st_reg.overload_cnt == OW'(OVERLOAD_LEN) && st_reg.shutdown_cnt == '0 |=>
      st_reg.shutdown_cnt == SW'(SHUTDOWN_LEN) && !gate_drive_output)
      else $error("overload did not start shutdown");
   a_gate_allowed: assert property (@(posedge pclk) disable iff (!presetn) // [RULE20]
      gate_drive_output |-> $past(allow))
      else $error("gate on while protection inhibits");
endmodule : pfcvp_protect

// File: dv/pfcvp_stage_model.sv
// Purpose: boost stage model feeding the valley and shunt comparators
// Assumes: gate_drive_output active high, single pclk domain
// Notes:   a zero setting disables that source
`timescale 1ns/1ps
module pfcvp_stage_model (
   // clock
   input wire logic pclk,
   // gate from the block
   input wire logic gate_drive_output,
   // settings from the bench
   input wire logic [7:0] ring_len,
   input wire logic [7:0] oc_at,
   input wire logic [7:0] sev_at,
   // comparators
   output logic valley_detect_input,
   output logic cycle_limit_cmp,
   output logic severe_limit_cmp
);
   logic [7:0] off_cnt = 8'h00;
   logic [7:0] on_cnt = 8'h00;
   always_ff @(posedge pclk) begin
      off_cnt <= (gate_drive_output || off_cnt == ring_len + 8'h03) ? 8'h00 : off_cnt + 8'h01;
      on_cnt <= gate_drive_output ? on_cnt + 8'h01 : 8'h00;
   end
   // ringing only while the switch is off: ring_len high samples, then four low
   assign valley_detect_input = !gate_drive_output && off_cnt < ring_len;
   // shunt spikes last four cycles; no current while off, on_cnt wraps after 256
   assign cycle_limit_cmp = gate_drive_output && oc_at != 8'h00 && on_cnt >= oc_at && on_cnt < oc_at + 8'h04;
   assign severe_limit_cmp = gate_drive_output && sev_at != 8'h00 && on_cnt >= sev_at && on_cnt < sev_at + 8'h04;
endmodule : pfcvp_stage_model

// File: dv/tb_top.sv
// Purpose: self-checking bench of the valley and protection block
// Assumes: shortened counts through parameters, pclk 100 MHz
// Notes:   stage model drives the comparators, the bench drives sense codes
`timescale 1ns/1ps
module tb_top;
   import pfcvp_pkg::*;
   localparam int BO_N = 50;
   localparam int OL_N = 100;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [APB_AW-1:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, q;
   logic pready, pslverr, valley, clim, slim, gate, vpulse, startup, standby, plim_act;
   logic [SENSE_W-1:0] line_s = 12'h3E8;
   logic [SENSE_W-1:0] link_s = SENSE_W'(REF_CODE);
   logic cyc_req = 1'b0;
   logic ot_end = 1'b0;
   logic p_lim = 1'b0;
   logic [7:0] ring_len = 8'h00;
   logic [7:0] oc_at = 8'h00;
   logic [7:0] sev_at = 8'h00;
   logic gate_d = 1'b0;
   int fail_count = 0;
   int total_checks = 0;
   int n_pulse = 0;
   int n_rise = 0;
   initial forever #5 pclk = ~pclk;
   pfcvp_protect #(.BO_DWELL(BO_N), .RESTART_LEN(40), .OVERLOAD_LEN(OL_N), .SHUTDOWN_LEN(60)) u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .valley_detect_input(valley), .line_sense_input(line_s), .link_feedback_input(link_s),
      .cycle_limit_cmp(clim), .severe_limit_cmp(slim), .cycle_request(cyc_req),
      .on_time_end(ot_end), .power_at_limit(p_lim), .gate_drive_output(gate),
      .valley_qualified_pulse(vpulse), .startup_mode(startup), .standby_mode(standby),
      .power_limit_active(plim_act));
   pfcvp_stage_model u_stage (.pclk(pclk), .gate_drive_output(gate), .ring_len(ring_len), .oc_at(oc_at),
      .sev_at(sev_at), .valley_detect_input(valley), .cycle_limit_cmp(clim), .severe_limit_cmp(slim));
   always @(posedge pclk) begin
      if (vpulse === 1'b1) n_pulse++;
      if (gate === 1'b1 && gate_d !== 1'b1) n_rise++;
      gate_d <= gate;
   end
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      total_checks++;
      if (got !== ex) begin
         fail_count++;
         $display("ERROR %s expected %0h seen %0h", nm, ex, got);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask : cyc
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      chk("pslverr", a > ADDR_VALLEY_CNT, pslverr);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [31:0] ex);
      apb(1'b0, a, 32'h0);
      chk("prdata", ex, q);
   endtask : rd
   task automatic start_cycle;
      int n;
      n = 0;
      cyc_req <= 1'b1;
      while (gate !== 1'b1 && n < 200) begin
         @(posedge pclk);
         n++;
      end
      cyc_req <= 1'b0;
      chk("gate start", 1'b1, gate);
   endtask : start_cycle
   task automatic end_cycle;
      ot_end <= 1'b1;
      @(posedge pclk);
      ot_end <= 1'b0;
      cyc(2);
      chk("gate end", 1'b0, gate);
   endtask : end_cycle
   task automatic t_regs;
      chk("gate idle", 1'b0, gate);
      rd(ADDR_CTRL, 32'h1);
      rd(ADDR_BO_LOW, BO_LOW_RST);
      rd(ADDR_BO_HIGH, BO_HIGH_RST);
      rd(ADDR_OVP_HYST, OVP_HYST_RST);
      apb(1'b1, 8'h18, 32'hFFFFFFFF);
      rd(8'h18, 32'h0);
      apb(1'b1, ADDR_BO_LOW, 32'hFFFFFFFF);
      rd(ADDR_BO_LOW, 32'hFFF);
      apb(1'b1, ADDR_BO_LOW, BO_LOW_RST);
      $display("test regs done");
   endtask : t_regs
   task automatic t_valley;
      int r;
      n_pulse = 0;
      ring_len <= 8'h13;
      cyc_req <= 1'b1;
      cyc(120);
      chk("pulse short", 0, n_pulse);
      chk("gate short", 1'b0, gate);
      cyc_req <= 1'b0;
      ring_len <= 8'h14;
      cyc(120);
      chk("pulses", 1'b1, n_pulse >= 4);
      chk("gate skip", 1'b0, gate);
      start_cycle();
      end_cycle();
      apb(1'b1, ADDR_CTRL, 32'h0);
      rd(ADDR_CTRL, 32'h0);
      r = n_rise;
      cyc_req <= 1'b1;
      cyc(60);
      chk("ctrl hold", r, n_rise);
      cyc_req <= 1'b0;
      apb(1'b1, ADDR_CTRL, 32'h1);
      $display("test valley done");
   endtask : t_valley
   task automatic t_ocp;
      oc_at <= 8'h0A;
      start_cycle();
      cyc(50);
      chk("gate blanking", 1'b1, gate);
      end_cycle();
      oc_at <= 8'h28;
      start_cycle();
      cyc(50);
      chk("gate cut", 1'b0, gate);
      oc_at <= 8'h00;
      $display("test overcurrent done");
   endtask : t_ocp
   task automatic t_severe;
      int r;
      sev_at <= 8'h23;
      start_cycle();
      cyc(45);
      chk("gate severe", 1'b0, gate);
      sev_at <= 8'h00;
      r = n_rise;
      cyc_req <= 1'b1;
      cyc(20);
      chk("restart block", r, n_rise);
      start_cycle();
      end_cycle();
      $display("test severe done");
   endtask : t_severe
   task automatic t_ovp;
      int r;
      start_cycle();
      link_s <= SENSE_W'(OVP_TRIP_CODE);
      cyc(5);
      chk("gate at trip", 1'b1, gate);
      link_s <= SENSE_W'(OVP_TRIP_CODE + 1);
      cyc(3);
      chk("gate ovp", 1'b0, gate);
      link_s <= SENSE_W'(OVP_TRIP_CODE - OVP_HYST_RST);
      r = n_rise;
      cyc_req <= 1'b1;
      cyc(80);
      chk("ovp hold", r, n_rise);
      link_s <= SENSE_W'(REF_CODE);
      start_cycle();
      end_cycle();
      $display("test overvoltage done");
   endtask : t_ovp
   task automatic t_brown;
      int r;
      line_s <= SENSE_W'(BO_LOW_RST - 1);
      cyc(BO_N - 10);
      line_s <= SENSE_W'(BO_HIGH_RST + 1);
      cyc(5);
      chk("standby short", 1'b0, standby);
      line_s <= SENSE_W'(BO_LOW_RST - 1);
      cyc(BO_N + 5);
      chk("standby set", 1'b1, standby);
      line_s <= SENSE_W'(BO_HIGH_RST);
      r = n_rise;
      cyc_req <= 1'b1;
      cyc(BO_N + 20);
      chk("brownout hold", r, n_rise);
      chk("standby hyst", 1'b1, standby);
      line_s <= SENSE_W'(BO_HIGH_RST + 1);
      cyc(BO_N - 10);
      chk("standby early", 1'b1, standby);
      cyc(15);
      chk("standby clear", 1'b0, standby);
      start_cycle();
      end_cycle();
      $display("test brownout done");
   endtask : t_brown
   task automatic t_mode;
      int r;
      link_s <= SENSE_W'(STARTUP_CODE);
      cyc(4);
      chk("startup at 90", 1'b0, startup);
      link_s <= SENSE_W'(STARTUP_CODE - 1);
      cyc(4);
      chk("startup entry", 1'b1, startup);
      link_s <= SENSE_W'(REF_CODE - 1);
      cyc(4);
      chk("startup kept", 1'b1, startup);
      link_s <= SENSE_W'(REF_CODE);
      cyc(4);
      chk("startup cancel", 1'b0, startup);
      p_lim <= 1'b1;
      cyc(4);
      chk("power limit", 1'b1, plim_act);
      cyc(OL_N);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("shutdown", 1'b1, q[ST_SHUTDOWN]);
      p_lim <= 1'b0;
      r = n_rise;
      cyc_req <= 1'b1;
      cyc(20);
      chk("shutdown hold", r, n_rise);
      start_cycle();
      end_cycle();
      $display("test overload done");
   endtask : t_mode
   task automatic results;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : results
   initial begin
      cyc(8);
      chk("startup rst", 1'b1, startup);
      chk("gate rst", 1'b0, gate);
      presetn <= 1'b1;
      t_regs();
      t_valley();
      t_ocp();
      t_severe();
      t_ovp();
      t_brown();
      t_mode();
      results();
   end
   initial begin
      cyc(20000);
      fail_count++;
      $display("ERROR watchdog expected end seen timeout");
      results();
   end
endmodule : tb_top
